// File: hdl/acs_defs.svh
/*
 * Constants for the channel scan and test select block: register addressing,
 * field positions, reset values. Assumes inclusion from the modules and the bench.
 */
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

// register address carried on data bits 11..10
`define ACS_ADDR_HI 11
`define ACS_ADDR_LO 10
`define ACS_ADDR_SEL 2'h0
`define ACS_ADDR_MODE 2'h1

// input select control fields
`define ACS_SEL_HI 7
`define ACS_SEL_LO 3
`define ACS_TEST_HI 9
`define ACS_TEST_LO 8
`define ACS_DIFF_BIT 5

// mode and reset control fields
`define ACS_DEVRST_BIT 0
`define ACS_SYNCCLR_BIT 1
`define ACS_PINMODE_BIT 6
`define ACS_FORMAT_BIT 7
`define ACS_OFFCAL_BIT 8
`define ACS_READBACK_BIT 9

// reset values
`define ACS_SEL_RESET 10'h020
`define ACS_MODE_RESET 10'h030

`endif

// File: hdl/acs_pkg.sv
/*
 * Types shared by the channel scan and test select block.
 * Assumes acs_defs.svh is available on the include path.
 */
package acs_pkg;
	// analog source driven to the sampler
	typedef enum logic [2:0] {
		ACS_SRC_A_POS = 3'h0,
		ACS_SRC_A_NEG = 3'h1,
		ACS_SRC_B_POS = 3'h2,
		ACS_SRC_B_NEG = 3'h3,
		ACS_SRC_A_DIFF = 3'h4,
		ACS_SRC_B_DIFF = 3'h5,
		ACS_SRC_NONE = 3'h7
	} acs_src_t;

	// test source replacing the analog input
	typedef enum logic [1:0] {
		ACS_TEST_NORMAL = 2'h0,
		ACS_TEST_UPPER = 2'h1,
		ACS_TEST_MID = 2'h2,
		ACS_TEST_LOWER = 2'h3
	} acs_test_t;

	// scan sequencer step, gray coded along the wrap path
	typedef enum logic [1:0] {
		ACS_STEP0 = 2'h0,
		ACS_STEP1 = 2'h1,
		ACS_STEP2 = 2'h3,
		ACS_STEP3 = 2'h2
	} acs_step_t;
endpackage : acs_pkg

// File: hdl/acs_step_decode.sv
/*
 * Combinational map from selection code and scan step to an analog source,
 * plus the sequence length. Assumes the caller registers the result.
 */
`timescale 1ns/1ps
`include "acs_defs.svh"

module acs_step_decode
	import acs_pkg::*;
(
	// selection
	input wire logic [4:0] selCode,
	input wire acs_step_t step,
	// result
	output acs_src_t source,
	output logic [2:0] seqLength,
	output logic codeValid
);
	// table lookup; reserved codes give no source
	always_comb begin
		source = ACS_SRC_NONE;
		seqLength = 3'h1;
		codeValid = 1'b1;
		unique case (selCode)
			5'h00: source = ACS_SRC_A_POS;
			5'h01: source = ACS_SRC_A_NEG;
			5'h02: source = ACS_SRC_B_POS;
			5'h03: source = ACS_SRC_B_NEG;
			5'h04: source = ACS_SRC_A_DIFF;
			5'h05: source = ACS_SRC_B_DIFF;
			5'h11: begin
				seqLength = 3'h2;
				source = (step == ACS_STEP0) ? ACS_SRC_A_POS : ACS_SRC_A_NEG;
			end
			5'h12: begin
				seqLength = 3'h3;
				source = (step == ACS_STEP0) ? ACS_SRC_A_POS :
					(step == ACS_STEP1) ? ACS_SRC_A_NEG : ACS_SRC_B_POS;
			end
			5'h13: begin
				seqLength = 3'h4;
				unique case (step)
					ACS_STEP0: source = ACS_SRC_A_POS;
					ACS_STEP1: source = ACS_SRC_A_NEG;
					ACS_STEP2: source = ACS_SRC_B_POS;
					ACS_STEP3: source = ACS_SRC_B_NEG;
				endcase
			end
			5'h15: begin
				seqLength = 3'h2;
				source = (step == ACS_STEP0) ? ACS_SRC_A_POS : ACS_SRC_B_DIFF;
			end
			5'h16: begin
				seqLength = 3'h3;
				source = (step == ACS_STEP0) ? ACS_SRC_A_POS :
					(step == ACS_STEP1) ? ACS_SRC_A_NEG : ACS_SRC_B_DIFF;
			end
			5'h19: begin
				seqLength = 3'h2;
				source = (step == ACS_STEP0) ? ACS_SRC_A_DIFF : ACS_SRC_B_DIFF;
			end
			default: codeValid = 1'b0; // reserved codes
		endcase
	end
endmodule : acs_step_decode

// File: hdl/acs_scan_select.sv
/*
 * Control register write port, channel selection, autoscan sequencer and
 * test source decode. Assumes the host drives the write strobe and data
 * from logic on clk, so no synchroniser is placed on them.
 */
`timescale 1ns/1ps
`include "acs_defs.svh"

module acs_scan_select
	import acs_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// host write port
	input wire logic writeStrobe,
	input wire logic [11:0] writeData,
	// converter timing
	input wire logic conversionDone,
	// selection outputs
	output acs_src_t analogSource,
	output acs_test_t testSource,
	output logic differentialMode,
	output logic scanActive,
	output logic selectionValid,
	// control register and reset view
	output logic [9:0] inputSelectControl,
	output logic [9:0] modeAndResetControl,
	output logic deviceInReset
);
	typedef struct packed {
		logic [9:0] selReg;
		logic [9:0] modeReg;
		acs_step_t step;
		acs_src_t src;
		acs_test_t test;
		logic diff;
		logic scan;
		logic valid;
	} acs_state_t;

	acs_state_t state;
	acs_state_t next_state;
	acs_src_t stepSource;
	logic [2:0] seqLength;
	logic codeValid;
	logic [1:0] writeAddr;
	logic devReset;
	logic syncClear;
	acs_step_t advancedStep;
	acs_step_t lookupStep;

	assign writeAddr = writeData[`ACS_ADDR_HI:`ACS_ADDR_LO];
	assign devReset = state.modeReg[`ACS_DEVRST_BIT];
	assign syncClear = state.modeReg[`ACS_SYNCCLR_BIT];

	// next step along the gray path, wrapping at the sequence length
	always_comb begin
		unique case (state.step)
			ACS_STEP0: advancedStep = (seqLength > 3'h1) ? ACS_STEP1 : ACS_STEP0;
			ACS_STEP1: advancedStep = (seqLength > 3'h2) ? ACS_STEP2 : ACS_STEP0;
			ACS_STEP2: advancedStep = (seqLength > 3'h3) ? ACS_STEP3 : ACS_STEP0;
			ACS_STEP3: advancedStep = ACS_STEP0;
		endcase
	end

	// lookup sees the step that will be live next cycle so outputs stay aligned
	assign lookupStep = next_state.step;

	acs_step_decode stepDecode (
		.selCode(next_state.selReg[`ACS_SEL_HI:`ACS_SEL_LO]),
		.step(lookupStep),
		.source(stepSource),
		.seqLength(seqLength),
		.codeValid(codeValid)
	);

	// register writes, sequencer and output decode
	always_comb begin
		next_state = state;
		if (writeStrobe) begin
			unique case (writeAddr)
				`ACS_ADDR_SEL: next_state.selReg = writeData[9:0];
				`ACS_ADDR_MODE: next_state.modeReg = writeData[9:0];
				default: ; // reserved addresses ignored
			endcase
		end
		// device reset bit holds both registers at reset values but keeps itself
		if (next_state.modeReg[`ACS_DEVRST_BIT]) begin
			next_state.selReg = `ACS_SEL_RESET;
			next_state.modeReg = `ACS_MODE_RESET | 10'h001;
		end
		// a fresh selection write or sync clear restarts the sequence
		if (next_state.modeReg[`ACS_SYNCCLR_BIT] || next_state.modeReg[`ACS_DEVRST_BIT] ||
			(writeStrobe && writeAddr == `ACS_ADDR_SEL)) begin
			next_state.step = ACS_STEP0;
		end else if (conversionDone && state.scan) begin
			next_state.step = advancedStep;
		end
		next_state.src = stepSource;
		next_state.valid = codeValid;
		next_state.diff = (stepSource == ACS_SRC_A_DIFF) || (stepSource == ACS_SRC_B_DIFF);
		next_state.scan = next_state.selReg[`ACS_SEL_HI] && codeValid && (seqLength > 3'h1);
		next_state.test = acs_test_t'(next_state.selReg[`ACS_TEST_HI:`ACS_TEST_LO]);
	end

	// one register stage for all state; sync reset
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state.selReg <= `ACS_SEL_RESET;
			state.modeReg <= `ACS_MODE_RESET;
			state.step <= ACS_STEP0;
			state.src <= ACS_SRC_A_DIFF;
			state.test <= ACS_TEST_NORMAL;
			state.diff <= 1'b1;
			state.scan <= 1'b0;
			state.valid <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	// outputs straight from flip-flops
	assign analogSource = state.src;
	assign testSource = state.test;
	assign differentialMode = state.diff;
	assign scanActive = state.scan;
	assign selectionValid = state.valid;
	assign inputSelectControl = state.selReg;
	assign modeAndResetControl = state.modeReg;
	assign deviceInReset = devReset;
	// sync clear is a level held by software; host pulses it while configuring
	logic unusedSync;
	assign unusedSync = syncClear;
endmodule : acs_scan_select

// File: verif/acs_scan_select_properties.sv
/* port checker for the scan select block
   assumes bind from the bench, one clock domain */
`timescale 1ns/1ps
module acs_scan_select_properties
	import acs_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// host side
	input wire logic writeStrobe,
	input wire logic [11:0] writeData,
	input wire logic conversionDone,
	// selection view
	input wire acs_src_t analogSource,
	input wire acs_test_t testSource,
	input wire logic differentialMode,
	input wire logic scanActive,
	input wire logic selectionValid,
	input wire logic [9:0] inputSelectControl,
	input wire logic [9:0] modeAndResetControl,
	input wire logic deviceInReset
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// quiet scan step and plain select write
	sequence s_step;
		scanActive && conversionDone && !writeStrobe && !modeAndResetControl[1];
	endsequence
	sequence s_selwr;
		writeStrobe && writeData[11:10] == 2'h0 && !deviceInReset;
	endsequence
	AST_SEL_WRITE: assert property (s_selwr |=> inputSelectControl == $past(writeData[9:0]))
		else $error("select write lost");
	AST_TEST: assert property (testSource == acs_test_t'(inputSelectControl[9:8]))
		else $error("test source wrong");
	AST_SINGLE: assert property (!scanActive && inputSelectControl[7:5] == 3'h0
		|-> analogSource == acs_src_t'({1'b0, inputSelectControl[4:3]}) && !differentialMode)
		else $error("single input wrong");
	AST_DIFF: assert property (inputSelectControl[7:4] == 4'h2
		|-> analogSource == acs_src_t'({2'b10, inputSelectControl[3]}) && differentialMode)
		else $error("pair wrong");
	AST_RSVD: assert property (!selectionValid |-> analogSource == ACS_SRC_NONE && !scanActive)
		else $error("reserved code used");
	AST_ADVANCE: assert property (s_step |=> analogSource != $past(analogSource))
		else $error("scan did not advance");
	AST_HOLD: assert property (!conversionDone && !writeStrobe |=> $stable(analogSource))
		else $error("source moved");
	AST_SYNC: assert property (scanActive && modeAndResetControl[1] && !writeStrobe
		|=> analogSource inside {ACS_SRC_A_POS, ACS_SRC_A_DIFF})
		else $error("no restart");
endmodule : acs_scan_select_properties

// File: verif/acs_host_model.sv
/* host model: writes control words, pulses conversion done
   assumes calls from the bench, outputs on rising clk */
`timescale 1ns/1ps
module acs_host_model (
	// clock
	input wire logic clk,
	// write port
	output logic writeStrobe = 1'b0,
	output logic [11:0] writeData = 12'h000,
	output logic conversionDone = 1'b0
);
	// one word, strobe high for one edge; stale data inverted
	task wr(input logic [11:0] d);
		@(posedge clk);
		writeStrobe <= 1'b1;
		writeData <= d;
		@(posedge clk);
		writeStrobe <= 1'b0;
		writeData <= ~d;
		#1;
	endtask : wr
	// end of one conversion
	task conv();
		@(posedge clk);
		conversionDone <= 1'b1;
		@(posedge clk);
		conversionDone <= 1'b0;
		#1;
	endtask : conv
	// scan setup wrapped in sync clear
	task scan(input logic [11:0] d);
		wr(12'h402);
		wr(d);
		wr(12'h400);
	endtask : scan
endmodule : acs_host_model

// File: verif/tb.sv
/* bench: select rows, scan table, reset cases
   assumes hdl and verif compiled together */
`timescale 1ns/1ps
`include "acs_defs.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
	$display("unexpected %0t %h %h", $time, a, b); end end
module tb
	import acs_pkg::*;
;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	int mismatches = 0;
	int compares = 0;
	wire logic writeStrobe;
	wire logic conversionDone;
	wire logic [11:0] writeData;
	acs_src_t analogSource;
	acs_test_t testSource;
	logic differentialMode, scanActive, selectionValid, deviceInReset;
	logic [9:0] inputSelectControl, modeAndResetControl;
	// rows: word, valid, source, test
	logic [17:0] rows [10] = '{{12'h000, 4'h8, 2'h0}, {12'h008, 4'h9, 2'h0}, {12'h010, 4'hA, 2'h0},
		{12'h018, 4'hB, 2'h0}, {12'h020, 4'hC, 2'h0}, {12'h028, 4'hD, 2'h0}, {12'h100, 4'h8, 2'h1},
		{12'h200, 4'h8, 2'h2}, {12'h300, 4'h8, 2'h3}, {12'h030, 4'h7, 2'h0}};
	// scans: word, steps after first, five 3-bit sources
	logic [29:0] scans [6] = '{{12'h088, 3'h2, 15'h0200}, {12'h090, 3'h3, 15'h0280},
		{12'h098, 3'h4, 15'h0298}, {12'h0A8, 3'h2, 15'h0A00}, {12'h0B0, 3'h3, 15'h0340},
		{12'h0C8, 3'h2, 15'h4B00}};
	// 25 MHz clock
	always #20 clk = ~clk;
	acs_host_model host (.clk(clk), .writeStrobe(writeStrobe), .writeData(writeData),
		.conversionDone(conversionDone));
	acs_scan_select dut (.*);
	// verdict
	task wrap_up();
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : wrap_up
	// hang guard, run needs well under this
	initial begin
		#200000;
		mismatches++;
		wrap_up();
	end
	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		#1;
		`CHK(inputSelectControl, `ACS_SEL_RESET)
		`CHK(analogSource, ACS_SRC_A_DIFF)
		for (int i = 0; i < 10; i++) begin
			host.wr(rows[i][17:6]);
			`CHK(analogSource, rows[i][4:2])
			`CHK(testSource, rows[i][1:0])
			`CHK(selectionValid, rows[i][5])
			`CHK(differentialMode, rows[i][5] & rows[i][4])
		end
		for (int i = 0; i < 6; i++) begin
			host.scan(scans[i][29:18]);
			`CHK(scanActive, 1'b1)
			for (int j = 0; j <= scans[i][17:15]; j++) begin
				if (j > 0) host.conv();
				`CHK(analogSource, scans[i][14 - 3 * j -: 3])
			end
		end
		// sync clear held freezes step 0
		host.wr(12'h402);
		host.conv();
		`CHK(analogSource, ACS_SRC_A_DIFF)
		// device reset ignores select writes, then bad address
		host.wr(12'h401);
		host.wr(12'h018);
		`CHK(inputSelectControl, `ACS_SEL_RESET)
		`CHK(deviceInReset, 1'b1)
		`CHK(modeAndResetControl, `ACS_MODE_RESET | 10'h001)
		host.wr(12'h400);
		`CHK(deviceInReset, 1'b0)
		`CHK(modeAndResetControl, 10'h000)
		host.wr(12'hC18);
		`CHK(inputSelectControl, `ACS_SEL_RESET)
		// mid-run reset returns every register to its reset value
		host.wr(12'h0C8);
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		#1;
		`CHK(inputSelectControl, `ACS_SEL_RESET)
		`CHK(modeAndResetControl, `ACS_MODE_RESET)
		`CHK(scanActive, 1'b0)
		`CHK(differentialMode, 1'b1)
		`CHK(analogSource, ACS_SRC_A_DIFF)
		wrap_up();
	end
endmodule : tb
bind acs_scan_select acs_scan_select_properties chk (.*);
